// ---- pmc_config.sv ----
`include "pmc_map.svh"
// Function
// [R1] power control register at 87H, resets to 00H, byte access only
// [R2] power control bit 7 doubles the serial port baud rate
// [R3] bit 6 lets a serial SPI or I2C interrupt end power-down
// [R4] bit 5 lets external interrupt zero end power-down, low level or falling edge
// [R5] bit 4 set stops the address latch strobe output
// [R6] writing 1 to bit 1 enters power-down until an enabled wake source
// [R7] power control bit 0 and configuration bits 6..1 ignore writes
// [R8] configuration register at AFH, resets 00H, plain stack and memory
// [R9] configuration bit 7 set makes the stack pointer 11 bits wide
// [R10] bit 7 clear hides the high stack byte, stack wraps FFH to 00H
// [R11] configuration bit 0 set maps on-chip data memory into lowest 2 kbytes
// [R12] bit 0 clear sends data moves to external memory up to 16 MB
// [R13] high stack byte at B7H, 3 low bits, accessible only when extended
// [R14] data pointer above 0007FFH always goes off-chip
// [R15] general flag bits 3 and 2 just hold what software writes
module pmc_config (
   input  wire logic                    clk,
   input  wire logic                    reset,
   input  wire logic                    clk_en,
   input  wire pmc_pkg::pmc_sfr_req_t   sfr_req,
   output logic [7:0]                   sfr_rdata,
   output logic                         sfr_hit,
   input  wire pmc_pkg::pmc_stack_op_t  stack_op,
   output logic [10:0]                  stack_pointer,
   input  wire logic [23:0]             data_pointer,
   output logic                         xdata_onchip_sel,
   input  wire logic                    serial_irq,
   input  wire logic                    external_interrupt_zero,
   input  wire logic                    ext_int_zero_edge_select,
   input  wire logic                    latch_strobe_core,
   output logic                         latch_strobe,
   output logic                         latch_strobe_oe_n,
   output logic                         baud_double,
   output logic                         powered_down,
   output logic                         general_flag_one,
   output logic                         general_flag_zero
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   pmc_pkg::pmc_power_control_t power_control_q;
   logic [7:0]                  cfg_q;
   logic [10:0]                 sp_q;
   logic [10:0]                 sp_d;
   pmc_pkg::pmc_power_state_t   pstate_q;
   logic                        external_interrupt_zero_level;
   logic                        external_interrupt_zero_fall;
   logic                        wake;
   logic                        ext_stack;

   // byte write under mask keeping unimplemented bits at zero
   function automatic logic [7:0] masked(input logic [7:0] v, input logic [7:0] m);
      masked = v & m;
   endfunction : masked

   // address match on a request
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_addr);
      hit = (a == ref_addr);
   endfunction : hit

   assign ext_stack = cfg_q[`PMC_BIT_EXTENDED_STACK];

   // ----------------------------------------
   // external interrupt zero pin synchroniser
   // ----------------------------------------
   pmc_wake_sync u_external_interrupt_zero_sync (
      .clk        (clk),
      .reset      (reset),
      .clk_en     (clk_en),
      .pin_in     (external_interrupt_zero),
      .level_out  (external_interrupt_zero_level),
      .fall_pulse (external_interrupt_zero_fall)
   );

   // ----------------------------------------
   // power control register
   // ----------------------------------------
   // write path, power-down bit cleared by wake
   always_ff @(posedge clk) begin
      if (reset) begin
         power_control_q <= `PMC_RST_POWER_CONTROL; // R1
      end else if (clk_en) begin
         if (sfr_req.wr && hit(sfr_req.addr, `PMC_ADDR_POWER_CONTROL)) begin
            power_control_q <= masked(sfr_req.wdata, `PMC_MASK_POWER_CONTROL); // R7 R15
         end else if (wake) begin
            power_control_q.power_down_request <= 1'b0; // R6
         end
      end
   end

   // wake sources gated by their enables
   always_comb begin
      wake = 1'b0;
      if (power_control_q.serial_wake_enable && serial_irq) begin
         wake = 1'b1; // R3
      end
      if (power_control_q.ext_int_zero_wake_enable) begin
         if (ext_int_zero_edge_select) begin
            wake = wake | external_interrupt_zero_fall; // R4
         end else begin
            wake = wake | !external_interrupt_zero_level; // R4
         end
      end
   end

   // power state machine
   always_ff @(posedge clk) begin
      if (reset) begin
         pstate_q <= pmc_pkg::PMC_RUNNING;
      end else if (clk_en) begin
         unique case (pstate_q)
            pmc_pkg::PMC_RUNNING: begin
               if (power_control_q.power_down_request && !wake) begin
                  pstate_q <= pmc_pkg::PMC_POWERED_DOWN; // R6
               end
            end
            pmc_pkg::PMC_POWERED_DOWN: begin
               if (wake) begin
                  pstate_q <= pmc_pkg::PMC_RUNNING; // R6
               end
            end
         endcase
      end
   end

   // ----------------------------------------
   // configuration register
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         cfg_q <= `PMC_RST_MEMORY_STACK_CONFIG; // R8
      end else if (clk_en && sfr_req.wr && hit(sfr_req.addr, `PMC_ADDR_MEMORY_STACK_CONFIG)) begin
         cfg_q <= masked(sfr_req.wdata, `PMC_MASK_MEMORY_STACK_CONFIG); // R7
      end
   end

   // ----------------------------------------
   // stack pointer
   // ----------------------------------------
   // next value: push/pop arithmetic and register writes
   always_comb begin
      sp_d = sp_q;
      unique case (stack_op)
         pmc_pkg::PMC_STACK_PUSH: sp_d = sp_q + 11'h001; // R9
         pmc_pkg::PMC_STACK_POP:  sp_d = sp_q - 11'h001;
         default:                 sp_d = sp_q;
      endcase
      if (sfr_req.wr && hit(sfr_req.addr, `PMC_ADDR_STACK_POINTER_LOW)) begin
         sp_d[7:0] = sfr_req.wdata;
      end
      if (sfr_req.wr && ext_stack && hit(sfr_req.addr, `PMC_ADDR_STACK_POINTER_HIGH)) begin
         sp_d[10:8] = sfr_req.wdata[2:0]; // R13
      end
      if (!ext_stack) begin
         sp_d[10:8] = 3'h0; // R10
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         sp_q <= `PMC_RST_STACK_POINTER;
      end else if (clk_en) begin
         sp_q <= sp_d;
      end
   end

   // ----------------------------------------
   // register read mux
   // ----------------------------------------
   always_comb begin
      sfr_rdata = 8'h00;
      sfr_hit   = 1'b0;
      if (hit(sfr_req.addr, `PMC_ADDR_POWER_CONTROL)) begin
         sfr_rdata = power_control_q;
         sfr_hit   = 1'b1;
      end else if (hit(sfr_req.addr, `PMC_ADDR_MEMORY_STACK_CONFIG)) begin
         sfr_rdata = cfg_q;
         sfr_hit   = 1'b1;
      end else if (hit(sfr_req.addr, `PMC_ADDR_STACK_POINTER_LOW)) begin
         sfr_rdata = sp_q[7:0];
         sfr_hit   = 1'b1;
      end else if (ext_stack && hit(sfr_req.addr, `PMC_ADDR_STACK_POINTER_HIGH)) begin
         sfr_rdata = {5'h00, sp_q[10:8]}; // R13
         sfr_hit   = 1'b1;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign stack_pointer     = sp_q;
   assign xdata_onchip_sel  = cfg_q[`PMC_BIT_ONCHIP_XDATA_MAP]
                              && (data_pointer <= `PMC_ONCHIP_XDATA_TOP); // R11 R12 R14
   assign latch_strobe      = latch_strobe_core && !power_control_q.latch_strobe_disable;
   assign latch_strobe_oe_n = power_control_q.latch_strobe_disable; // R5
   assign baud_double       = power_control_q.baud_double; // R2
   assign powered_down      = (pstate_q == pmc_pkg::PMC_POWERED_DOWN);
   assign general_flag_one  = power_control_q.general_flag_one;
   assign general_flag_zero = power_control_q.general_flag_zero;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   sequence s_power_control_write;
      clk_en && sfr_req.wr && sfr_req.addr == `PMC_ADDR_POWER_CONTROL;
   endsequence

   a_power_control_bit_zero: assert property (power_control_q[0] == 1'b0) // R7
      else $error("power control bit 0 not zero");
   a_cfg_unimpl_bits: assert property (cfg_q[6:1] == 6'h00) // R7
      else $error("config unimplemented bits set");
   a_baud_follows_write: assert property (s_power_control_write |=> baud_double == $past(sfr_req.wdata[7])) // R2
      else $error("baud double not set by write");
   a_strobe_off: assert property (power_control_q.latch_strobe_disable |-> latch_strobe_oe_n && !latch_strobe) // R5
      else $error("latch strobe driven while disabled");
   a_serial_wake: assert property (powered_down && clk_en && power_control_q.serial_wake_enable && serial_irq
                                   |=> !powered_down) // R3
      else $error("serial interrupt did not wake");
   a_pd_entry: assert property ((s_power_control_write ##0 sfr_req.wdata[1]) ##1 (clk_en && !wake && !sfr_req.wr)
                                |=> powered_down) // R6
      else $error("power-down not entered");
   a_pd_clear_wake: assert property (clk_en && wake && !sfr_req.wr |=> !power_control_q.power_down_request) // R6
      else $error("power-down request not cleared by wake");
   a_stack_wrap: assert property (clk_en && !ext_stack && sp_q[7:0] == 8'hFF && stack_op == pmc_pkg::PMC_STACK_PUSH
                                  && !sfr_req.wr |=> sp_q == 11'h000) // R10
      else $error("8-bit stack did not wrap");
   a_stack_extend: assert property (clk_en && ext_stack && sp_q == 11'h0FF && stack_op == pmc_pkg::PMC_STACK_PUSH
                                    && !sfr_req.wr |=> sp_q == 11'h100) // R9
      else $error("extended stack did not carry");
   a_xdata_limit: assert property (data_pointer > `PMC_ONCHIP_XDATA_TOP |-> !xdata_onchip_sel) // R14
      else $error("high address routed on-chip");
   a_sph_hidden: assert property (!ext_stack && sfr_req.addr == `PMC_ADDR_STACK_POINTER_HIGH |-> !sfr_hit) // R13
      else $error("high stack byte visible");
endmodule : pmc_config

// ---- pmc_map.svh ----
`ifndef PMC_MAP_SVH
`define PMC_MAP_SVH
// ----------------------------------------
// special function register addresses
// ----------------------------------------
`define PMC_ADDR_POWER_CONTROL       8'h87
`define PMC_ADDR_MEMORY_STACK_CONFIG 8'hAF
`define PMC_ADDR_STACK_POINTER_LOW  8'h81
`define PMC_ADDR_STACK_POINTER_HIGH 8'hB7
// ----------------------------------------
// reset values
// ----------------------------------------
`define PMC_RST_POWER_CONTROL       8'h00
`define PMC_RST_MEMORY_STACK_CONFIG 8'h00
`define PMC_RST_STACK_POINTER       11'h007
// ----------------------------------------
// field positions
// ----------------------------------------
`define PMC_BIT_BAUD_DOUBLE          7
`define PMC_BIT_SERIAL_WAKE          6
`define PMC_BIT_EXT_INT_ZERO_WAKE    5
`define PMC_BIT_LATCH_STROBE_DISABLE 4
`define PMC_BIT_GENERAL_FLAG_ONE     3
`define PMC_BIT_GENERAL_FLAG_ZERO    2
`define PMC_BIT_POWER_DOWN_REQUEST   1
`define PMC_BIT_EXTENDED_STACK       7
`define PMC_BIT_ONCHIP_XDATA_MAP     0
// ----------------------------------------
// writable masks and memory limits
// ----------------------------------------
`define PMC_MASK_POWER_CONTROL       8'hFE
`define PMC_MASK_MEMORY_STACK_CONFIG 8'h81
`define PMC_ONCHIP_XDATA_TOP         24'h0007FF
`endif

// ---- pmc_pkg.sv ----
package pmc_pkg;
   // ----------------------------------------
   // grouped carriers
   // ----------------------------------------
   typedef struct packed {
      logic       baud_double;
      logic       serial_wake_enable;
      logic       ext_int_zero_wake_enable;
      logic       latch_strobe_disable;
      logic       general_flag_one;
      logic       general_flag_zero;
      logic       power_down_request;
      logic       unused0;
   } pmc_power_control_t;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [7:0]  wdata;
   } pmc_sfr_req_t;

   typedef enum logic [1:0] {
      PMC_STACK_HOLD,
      PMC_STACK_PUSH,
      PMC_STACK_POP
   } pmc_stack_op_t;

   typedef enum logic {
      PMC_RUNNING,
      PMC_POWERED_DOWN
   } pmc_power_state_t;
endpackage : pmc_pkg

// ---- pmc_wake_sync.sv ----
`include "pmc_map.svh"
// ----------------------------------------
// pin synchroniser with agreement filter
// ----------------------------------------
module pmc_wake_sync (
   input  wire logic clk,
   input  wire logic reset,
   input  wire logic clk_en,
   input  wire logic pin_in,
   output logic      level_out,
   output logic      fall_pulse
);
   logic s1_q;
   logic s2_q;
   logic s3_q;
   logic lvl_q;

   // three stage shift, reset high (idle pin)
   always_ff @(posedge clk) begin
      if (reset) begin
         s1_q <= 1'b1;
         s2_q <= 1'b1;
         s3_q <= 1'b1;
      end else if (clk_en) begin
         s1_q <= pin_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // accept change once stages two and three agree
   always_ff @(posedge clk) begin
      if (reset) begin
         lvl_q <= 1'b1;
      end else if (clk_en && (s2_q == s3_q)) begin
         lvl_q <= s3_q;
      end
   end

   assign level_out  = lvl_q;
   assign fall_pulse = clk_en && (s2_q == s3_q) && !s3_q && lvl_q;
endmodule : pmc_wake_sync

// ---- power_and_memory_config_tb.sv ----
`include "pmc_map.svh"
module power_and_memory_config_tb;
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // stimulus and observed signals
   // ----------------------------------------
   logic                   clk;
   logic                   reset;
   logic                   clk_en;
   pmc_pkg::pmc_sfr_req_t  req;
   pmc_pkg::pmc_stack_op_t stack_op;
   logic [23:0]            data_pointer;
   logic                   serial_irq;
   logic                   ext_pin;
   logic                   edge_sel;
   logic                   strobe_core;
   logic [7:0]             rdata;
   logic                   hit;
   logic [10:0]            sp;
   logic                   onchip_sel;
   logic                   strobe;
   logic                   strobe_oe_n;
   logic                   baud_double;
   logic                   powered_down;
   logic                   flag_one;
   logic                   flag_zero;
   int                     n_mismatch;
   int                     checks_done;
   int                     cycles;

   pmc_config dut (
      .clk                      (clk),
      .reset                    (reset),
      .clk_en                   (clk_en),
      .sfr_req                  (req),
      .sfr_rdata                (rdata),
      .sfr_hit                  (hit),
      .stack_op                 (stack_op),
      .stack_pointer            (sp),
      .data_pointer             (data_pointer),
      .xdata_onchip_sel         (onchip_sel),
      .serial_irq               (serial_irq),
      .external_interrupt_zero  (ext_pin),
      .ext_int_zero_edge_select (edge_sel),
      .latch_strobe_core        (strobe_core),
      .latch_strobe             (strobe),
      .latch_strobe_oe_n        (strobe_oe_n),
      .baud_double              (baud_double),
      .powered_down             (powered_down),
      .general_flag_one         (flag_one),
      .general_flag_zero        (flag_zero)
   );

   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic complete_run;
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : complete_run

   task automatic chk_val(input string what, input logic [10:0] exp, input logic [10:0] got);
      checks_done++;
      if (got !== exp) begin
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
         n_mismatch++;
      end
   endtask : chk_val

   task automatic chk_bit(input string what, input logic exp, input logic got);
      checks_done++;
      if (got !== exp) begin
         $display("MISMATCH %s expected %b seen %b", what, exp, got);
         n_mismatch++;
      end
   endtask : chk_bit

   // one write strobe, then a quiet cycle
   task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
      req.wr = 1'b1;
      req.addr = a;
      req.wdata = d;
      @(negedge clk);
      req.wr = 1'b0;
      @(negedge clk);
   endtask : sfr_write

   // read data is combinational on the address
   task automatic sfr_read(input logic [7:0] a, input logic [7:0] exp);
      req.addr = a;
      #1;
      chk_val("sfr_rdata", {3'h0, exp}, {3'h0, rdata});
   endtask : sfr_read

   task automatic stack_step(input pmc_pkg::pmc_stack_op_t op);
      stack_op = op;
      @(negedge clk);
      stack_op = pmc_pkg::PMC_STACK_HOLD;
   endtask : stack_step

   // bounded wait for the filtered wake to land
   task automatic wait_wake;
      for (int i = 0; i < 10 && powered_down !== 1'b0; i++) @(negedge clk);
      chk_bit("powered_down", 1'b0, powered_down);
   endtask : wait_wake

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic test_reset;
      sfr_read(`PMC_ADDR_POWER_CONTROL, 8'h00);
      sfr_read(`PMC_ADDR_MEMORY_STACK_CONFIG, 8'h00);
      chk_val("stack_pointer", 11'h007, sp);
      chk_bit("powered_down", 1'b0, powered_down);
      chk_bit("latch_strobe_oe_n", 1'b0, strobe_oe_n);
   endtask : test_reset

   task automatic test_power_bits;
      sfr_write(`PMC_ADDR_POWER_CONTROL, 8'hFD);
      sfr_read(`PMC_ADDR_POWER_CONTROL, 8'hFC);
      chk_bit("baud_double", 1'b1, baud_double);
      chk_bit("general_flag_one", 1'b1, flag_one);
      chk_bit("general_flag_zero", 1'b1, flag_zero);
      chk_bit("latch_strobe_oe_n", 1'b1, strobe_oe_n);
      chk_bit("latch_strobe", 1'b0, strobe);
      chk_bit("powered_down", 1'b0, powered_down);
      sfr_write(`PMC_ADDR_POWER_CONTROL, 8'h08);
      sfr_read(`PMC_ADDR_POWER_CONTROL, 8'h08);
      chk_bit("baud_double", 1'b0, baud_double);
      chk_bit("general_flag_zero", 1'b0, flag_zero);
      chk_bit("latch_strobe_oe_n", 1'b0, strobe_oe_n);
      chk_bit("latch_strobe", 1'b1, strobe);
   endtask : test_power_bits

   task automatic test_config;
      sfr_write(`PMC_ADDR_MEMORY_STACK_CONFIG, 8'hFF);
      sfr_read(`PMC_ADDR_MEMORY_STACK_CONFIG, 8'h81);
      sfr_read(8'h90, 8'h00);
      chk_bit("sfr_hit", 1'b0, hit);
      sfr_write(`PMC_ADDR_MEMORY_STACK_CONFIG, 8'h00);
   endtask : test_config

   task automatic test_stack;
      sfr_write(`PMC_ADDR_STACK_POINTER_LOW, 8'hFF);
      stack_step(pmc_pkg::PMC_STACK_PUSH);
      chk_val("stack_pointer", 11'h000, sp);
      sfr_write(`PMC_ADDR_STACK_POINTER_HIGH, 8'h05);
      sfr_read(`PMC_ADDR_STACK_POINTER_HIGH, 8'h00);
      chk_bit("sfr_hit", 1'b0, hit);
      chk_val("stack_pointer", 11'h000, sp);
      sfr_write(`PMC_ADDR_MEMORY_STACK_CONFIG, 8'h80);
      sfr_write(`PMC_ADDR_STACK_POINTER_LOW, 8'hFF);
      stack_step(pmc_pkg::PMC_STACK_PUSH);
      chk_val("stack_pointer", 11'h100, sp);
      sfr_read(`PMC_ADDR_STACK_POINTER_HIGH, 8'h01);
      chk_bit("sfr_hit", 1'b1, hit);
      stack_step(pmc_pkg::PMC_STACK_POP);
      chk_val("stack_pointer", 11'h0FF, sp);
      sfr_write(`PMC_ADDR_MEMORY_STACK_CONFIG, 8'h00);
   endtask : test_stack

   task automatic test_xdata;
      sfr_write(`PMC_ADDR_MEMORY_STACK_CONFIG, 8'h01);
      data_pointer = 24'h0007FF;
      #1;
      chk_bit("xdata_onchip_sel", 1'b1, onchip_sel);
      data_pointer = 24'h000800;
      #1;
      chk_bit("xdata_onchip_sel", 1'b0, onchip_sel);
      data_pointer = 24'h000000;
      sfr_write(`PMC_ADDR_MEMORY_STACK_CONFIG, 8'h00);
      chk_bit("xdata_onchip_sel", 1'b0, onchip_sel);
   endtask : test_xdata

   task automatic test_serial_wake;
      sfr_write(`PMC_ADDR_POWER_CONTROL, 8'h42);
      chk_bit("powered_down", 1'b1, powered_down);
      serial_irq = 1'b1;
      @(negedge clk);
      serial_irq = 1'b0;
      chk_bit("powered_down", 1'b0, powered_down);
      sfr_read(`PMC_ADDR_POWER_CONTROL, 8'h40);
   endtask : test_serial_wake

   task automatic test_pin_wake;
      sfr_write(`PMC_ADDR_POWER_CONTROL, 8'h22);
      serial_irq = 1'b1;
      repeat (3) @(negedge clk);
      serial_irq = 1'b0;
      chk_bit("powered_down", 1'b1, powered_down);
      ext_pin = 1'b0;
      wait_wake();
      ext_pin = 1'b1;
      edge_sel = 1'b1;
      repeat (6) @(negedge clk);
      sfr_write(`PMC_ADDR_POWER_CONTROL, 8'h22);
      repeat (8) @(negedge clk);
      chk_bit("powered_down", 1'b1, powered_down);
      ext_pin = 1'b0;
      wait_wake();
      ext_pin = 1'b1;
   endtask : test_pin_wake

   // frozen clock enable, then a mid-run reset and a write right after it
   task automatic test_freeze_reset;
      clk_en = 1'b0;
      sfr_write(`PMC_ADDR_POWER_CONTROL, 8'h80);
      stack_step(pmc_pkg::PMC_STACK_PUSH);
      sfr_read(`PMC_ADDR_POWER_CONTROL, 8'h20);
      chk_val("stack_pointer", 11'h0FF, sp);
      clk_en = 1'b1;
      sfr_write(`PMC_ADDR_MEMORY_STACK_CONFIG, 8'h80);
      sfr_write(`PMC_ADDR_POWER_CONTROL, 8'h9C);
      reset = 1'b1;
      repeat (2) @(negedge clk);
      reset = 1'b0;
      sfr_read(`PMC_ADDR_POWER_CONTROL, 8'h00);
      sfr_read(`PMC_ADDR_MEMORY_STACK_CONFIG, 8'h00);
      chk_val("stack_pointer", 11'h007, sp);
      chk_bit("latch_strobe_oe_n", 1'b0, strobe_oe_n);
      chk_bit("baud_double", 1'b0, baud_double);
      sfr_write(`PMC_ADDR_POWER_CONTROL, 8'h80);
      chk_bit("baud_double", 1'b1, baud_double);
   endtask : test_freeze_reset

   // ----------------------------------------
   // clock, watchdog and main sequence
   // ----------------------------------------
   always #10 clk = ~clk;

   // cut a hang short
   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         n_mismatch++;
         complete_run();
      end
   end

   // reset, then the scenarios in turn
   initial begin
      clk = 1'b0;
      reset = 1'b1;
      clk_en = 1'b1;
      req = '0;
      stack_op = pmc_pkg::PMC_STACK_HOLD;
      data_pointer = 24'h000000;
      serial_irq = 1'b0;
      ext_pin = 1'b1;
      edge_sel = 1'b0;
      strobe_core = 1'b1;
      n_mismatch = 0;
      checks_done = 0;
      cycles = 0;
      repeat (8) @(negedge clk);
      reset = 1'b0;
      test_reset();
      test_power_bits();
      test_config();
      test_stack();
      test_xdata();
      test_serial_wake();
      test_pin_wake();
      test_freeze_reset();
      complete_run();
   end
endmodule : power_and_memory_config_tb
